/* spbu_regs.vh */
// spbu_regs.vh: register map, field positions, reset values and timing
// assumes inclusion by spbu_link_bringup.v; definitions only
`ifndef SPBU_REGS_VH
`define SPBU_REGS_VH

// register byte offsets (apb, 32-bit aligned words)
`define SPBU_CTRL_OFS         8'h00
`define SPBU_EVENT_OFS        8'h04
`define SPBU_CFGMSG_OFS       8'h08
`define SPBU_STATUS_OFS       8'h0c

// ctrl fields
`define SPBU_CTRL_DUAL_BIT    0
`define SPBU_CTRL_SOLO_BIT    1
`define SPBU_CTRL_RST         2'h0

// event fields, write one to trigger
`define SPBU_EVT_POWER_ON_SELF_TEST_BIT     0
`define SPBU_EVT_TOTAL_BIT    1
`define SPBU_EVT_ABS_BIT      2
`define SPBU_EVT_ERP_BIT      3

// configure-port message fields
`define SPBU_CFG_RATE_LSB     0
`define SPBU_CFG_RATE_MSB     3
`define SPBU_CFG_REFL_BIT     4
`define SPBU_CFG_NORM_BIT     5
`define SPBU_CFG_RST          6'h00

// status fields
`define SPBU_ST_FSM_LSB       0
`define SPBU_ST_FSM_MSB       7
`define SPBU_ST_OPER_BIT      8
`define SPBU_ST_RATE_BIT      9
`define SPBU_ST_REFL_BIT      10
`define SPBU_ST_STEP_LSB      11
`define SPBU_ST_STEP_MSB      12
`define SPBU_ST_PRIV_BIT      13
`define SPBU_ST_PST_LSB       14
`define SPBU_ST_PST_MSB       15
`define SPBU_ST_OWED_LSB      16
`define SPBU_ST_OWED_MSB      17
`define SPBU_ST_AWAIT_LSB     18
`define SPBU_ST_AWAIT_MSB     19

// port states
`define SPBU_PST_DISABLED     2'h0
`define SPBU_PST_ENABLED      2'h1
`define SPBU_PST_READY        2'h2

// transmit character selection
`define SPBU_TX_NONE          2'h0
`define SPBU_TX_TRAIN         2'h1
`define SPBU_TX_IDLE          2'h2
`define SPBU_TX_READY_PAIR    2'h3

// character counts
`define SPBU_TRAIN_CHARS      8'hc8
`define SPBU_IDLE_CHARS       8'h0a
`define SPBU_READY_INIT       2'h1

// timing: clock rate and nominal dual-speed step lengths
`define SPBU_CLK_MHZ          250
`define SPBU_STEP0_US         400
`define SPBU_STEP1_US         200
`define SPBU_STEP2_US         100
`define SPBU_STEP3_US         300

`endif

/* spbu_sync2.v */
// spbu_sync2.v: two-flop synchroniser for asynchronous level inputs
// assumes input levels are slow relative to pclk
`timescale 1ns/1ns
module spbu_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // async level in, synchronised level out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

/* spbu_link_bringup.v */
// spbu_link_bringup.v: serial port bring-up, speed negotiation, reflect flag
// assumes transmitter/receiver logic on pclk; line fault comes from a pin
//
// Function
// - power_on_self_test, resets, recovery alert or rate renegotiation force disabled privileged
// - hold off while the line fault detector reports a fault
// - after fault clears run speed negotiation, then set operational
// - after operational, send at least ten idle characters
// - with one frame of receive space, send ready pair, decrement owed count
// - on peer ready pair decrement awaited count; then privileged traffic allowed
// - negotiation ends on sync plus decoded idle character: ready state
// - single speed: 200 training chars, enabled, idle chars until ready
// - dual speed cycles 400/400us, 200/200us, 400/100us, 200/300us
// - each step sets rate, forces disabled, starts timer, sends 200 training
// - step lengths within ten percent; kept at nominal
// - sync inside a step: enabled, switch training to idle chars
// - idle char decoded before timer expiry: ready, keep current rate
// - after fourth step fails restart at first step, forever
// - reflect indicator set makes ports reflect token chars, else forward
// - reflect set: solo/switch node, port stops operational, cfg reflect set
// - reflect cleared only: dual node, both operational, cfg reflect clear
`timescale 1ns/1ns
`include "spbu_regs.vh"
module spbu_link_bringup #(
  parameter [16:0] STEP0_CYC = `SPBU_STEP0_US * `SPBU_CLK_MHZ,
  parameter [16:0] STEP1_CYC = `SPBU_STEP1_US * `SPBU_CLK_MHZ,
  parameter [16:0] STEP2_CYC = `SPBU_STEP2_US * `SPBU_CLK_MHZ,
  parameter [16:0] STEP3_CYC = `SPBU_STEP3_US * `SPBU_CLK_MHZ
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // line status
  input  wire        line_fault,
  input  wire        char_sync,
  input  wire        flag_decoded,
  input  wire        rx_ready_pair,
  input  wire        rx_space_avail,
  input  wire        peer_port_operational,
  // transmitter control
  input  wire        tx_char_done,
  output reg  [1:0]  tx_char_sel,
  output reg         rate_400,
  // port status
  output reg  [1:0]  port_state,
  output reg         privileged_mode,
  output reg         operational,
  output reg         privileged_traffic_ok,
  output reg         reflect_tokens_indicator
);

  localparam [7:0] ST_FAULT = 8'h01;
  localparam [7:0] ST_TRAIN = 8'h02;
  localparam [7:0] ST_ENAB  = 8'h04;
  localparam [7:0] ST_IDLE  = 8'h08;
  localparam [7:0] ST_BUF   = 8'h10;
  localparam [7:0] ST_PAIR  = 8'h20;
  localparam [7:0] ST_WAIT  = 8'h40;
  localparam [7:0] ST_UP    = 8'h80;

  reg  [7:0]  state;
  reg  [1:0]  step;
  reg  [16:0] timer;
  reg         timer_run;
  reg  [7:0]  chars;
  reg  [1:0]  owed_ready_count;
  reg  [1:0]  awaited_ready_count;
  reg  [1:0]  ctrl;
  reg  [5:0]  cfgmsg;
  reg         oper_prev;
  reg         peer_prev;
  reg  [16:0] next_step_cyc;
  reg  [31:0] next_prdata;
  reg  [1:0]  sync_fill;
  wire        line_fault_q;
  wire        line_fault_s;
  wire        dual_speed;
  wire        solo_node;
  wire        acc;
  wire        wr;
  wire        mapped;
  wire        evt_wr;
  wire        cfg_wr;
  wire        restart;
  wire        step_expired;
  wire [1:0]  next_step;
  wire        link_on;
  wire        peer_pair;

  spbu_sync2 #(
    .WIDTH (1)
  ) u_fault_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (line_fault),
    .sync_out (line_fault_q)
  );

  // synchroniser flops reset to no-fault; report a fault until they hold real samples
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_fill <= 2'h0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  assign line_fault_s = line_fault_q | ~sync_fill[1];

  // apb decode, zero wait state
  assign pready  = 1'b1;
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign mapped  = (paddr == `SPBU_CTRL_OFS) | (paddr == `SPBU_EVENT_OFS) |
                   (paddr == `SPBU_CFGMSG_OFS) | (paddr == `SPBU_STATUS_OFS);
  assign pslverr = acc & ~mapped;
  assign evt_wr  = wr & (paddr == `SPBU_EVENT_OFS);
  assign cfg_wr  = wr & (paddr == `SPBU_CFGMSG_OFS);

  assign dual_speed = ctrl[`SPBU_CTRL_DUAL_BIT];
  assign solo_node  = ctrl[`SPBU_CTRL_SOLO_BIT];

  assign restart = (evt_wr & (pwdata[`SPBU_EVT_POWER_ON_SELF_TEST_BIT] | pwdata[`SPBU_EVT_TOTAL_BIT] |
                    pwdata[`SPBU_EVT_ABS_BIT] | pwdata[`SPBU_EVT_ERP_BIT])) |
                   (cfg_wr & (|pwdata[`SPBU_CFG_RATE_MSB:`SPBU_CFG_RATE_LSB]));

  assign step_expired = timer_run & (timer == 17'h00000);
  assign next_step    = step + 2'h1;
  assign link_on      = (state == ST_IDLE) | (state == ST_BUF) | (state == ST_PAIR) |
                        (state == ST_WAIT) | (state == ST_UP);
  assign peer_pair    = rx_ready_pair & link_on & (awaited_ready_count != 2'h0);

  // step lengths at nominal, no deliberate tolerance
  always @* begin
    case (next_step)
      2'h0:    next_step_cyc = STEP0_CYC - 17'h00001;
      2'h1:    next_step_cyc = STEP1_CYC - 17'h00001;
      2'h2:    next_step_cyc = STEP2_CYC - 17'h00001;
      default: next_step_cyc = STEP3_CYC - 17'h00001;
    endcase
  end

  // registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= `SPBU_CTRL_RST;
      cfgmsg <= `SPBU_CFG_RST;
    end else begin
      if (wr & (paddr == `SPBU_CTRL_OFS)) begin
        ctrl <= pwdata[1:0];
      end
      if (cfg_wr) begin
        cfgmsg <= pwdata[5:0];
      end
    end
  end

  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `SPBU_CTRL_OFS: begin
        next_prdata[1:0] = ctrl;
      end
      `SPBU_CFGMSG_OFS: begin
        next_prdata[5:0] = cfgmsg;
      end
      `SPBU_STATUS_OFS: begin
        next_prdata[`SPBU_ST_FSM_MSB:`SPBU_ST_FSM_LSB]     = state;
        next_prdata[`SPBU_ST_OPER_BIT]                     = operational;
        next_prdata[`SPBU_ST_RATE_BIT]                     = rate_400;
        next_prdata[`SPBU_ST_REFL_BIT]                     = reflect_tokens_indicator;
        next_prdata[`SPBU_ST_STEP_MSB:`SPBU_ST_STEP_LSB]   = step;
        next_prdata[`SPBU_ST_PRIV_BIT]                     = privileged_mode;
        next_prdata[`SPBU_ST_PST_MSB:`SPBU_ST_PST_LSB]     = port_state;
        next_prdata[`SPBU_ST_OWED_MSB:`SPBU_ST_OWED_LSB]   = owed_ready_count;
        next_prdata[`SPBU_ST_AWAIT_MSB:`SPBU_ST_AWAIT_LSB] = awaited_ready_count;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      prdata <= next_prdata;
    end
  end

  // bring-up sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state               <= ST_FAULT;
      step                <= 2'h0;
      timer               <= 17'h00000;
      timer_run           <= 1'b0;
      chars               <= 8'h00;
      rate_400            <= 1'b1;
      port_state          <= `SPBU_PST_DISABLED;
      privileged_mode     <= 1'b1;
      operational         <= 1'b0;
      owed_ready_count    <= `SPBU_READY_INIT;
      awaited_ready_count <= `SPBU_READY_INIT;
      tx_char_sel         <= `SPBU_TX_NONE;
    end else if (restart) begin
      state               <= ST_FAULT;
      step                <= 2'h0;
      timer_run           <= 1'b0;
      chars               <= 8'h00;
      port_state          <= `SPBU_PST_DISABLED;
      privileged_mode     <= 1'b1;
      operational         <= 1'b0;
      owed_ready_count    <= `SPBU_READY_INIT;
      awaited_ready_count <= `SPBU_READY_INIT;
      tx_char_sel         <= `SPBU_TX_NONE;
    end else begin
      if (timer_run & (timer != 17'h00000)) begin
        timer <= timer - 17'h00001;
      end
      if (cfg_wr & pwdata[`SPBU_CFG_NORM_BIT]) begin
        privileged_mode <= 1'b0;
      end
      if (peer_pair) begin
        awaited_ready_count <= awaited_ready_count - 2'h1;
      end
      case (state)
        ST_FAULT: begin
          if (!line_fault_s) begin
            state       <= ST_TRAIN;
            step        <= 2'h0;
            rate_400    <= 1'b1;
            timer       <= STEP0_CYC - 17'h00001;
            timer_run   <= dual_speed;
            chars       <= 8'h00;
            port_state  <= `SPBU_PST_DISABLED;
            tx_char_sel <= `SPBU_TX_TRAIN;
          end
        end
        ST_TRAIN: begin
          if (tx_char_done & (chars != `SPBU_TRAIN_CHARS)) begin
            chars <= chars + 8'h01;
          end
          if (step_expired) begin
            step        <= next_step;
            rate_400    <= ~next_step[0];
            timer       <= next_step_cyc;
            chars       <= 8'h00;
          end else if ((chars == `SPBU_TRAIN_CHARS) & (~dual_speed | char_sync)) begin
            state       <= ST_ENAB;
            port_state  <= `SPBU_PST_ENABLED;
            tx_char_sel <= `SPBU_TX_IDLE;
          end
        end
        ST_ENAB: begin
          if (char_sync & flag_decoded) begin
            state       <= ST_IDLE;
            port_state  <= `SPBU_PST_READY;
            operational <= 1'b1;
            timer_run   <= 1'b0;
            chars       <= 8'h00;
          end else if (step_expired) begin
            state       <= ST_TRAIN;
            step        <= next_step;
            rate_400    <= ~next_step[0];
            timer       <= next_step_cyc;
            chars       <= 8'h00;
            port_state  <= `SPBU_PST_DISABLED;
            tx_char_sel <= `SPBU_TX_TRAIN;
          end
        end
        ST_IDLE: begin
          if (tx_char_done) begin
            chars <= chars + 8'h01;
            if (chars == `SPBU_IDLE_CHARS - 8'h01) begin
              state <= ST_BUF;
            end
          end
        end
        ST_BUF: begin
          if (rx_space_avail) begin
            state       <= ST_PAIR;
            tx_char_sel <= `SPBU_TX_READY_PAIR;
          end
        end
        ST_PAIR: begin
          if (tx_char_done) begin
            state            <= ST_WAIT;
            tx_char_sel      <= `SPBU_TX_IDLE;
            owed_ready_count <= owed_ready_count - 2'h1;
          end
        end
        ST_WAIT: begin
          if ((awaited_ready_count == 2'h0) | peer_pair) begin
            state <= ST_UP;
          end
        end
        ST_UP: begin
          state <= ST_UP;
        end
        default: begin
          state <= ST_FAULT;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      privileged_traffic_ok <= 1'b0;
    end else begin
      privileged_traffic_ok <= (state == ST_UP) & ~restart;
    end
  end

  // reflect indicator; set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reflect_tokens_indicator <= 1'b1;
      oper_prev                <= 1'b0;
      peer_prev                <= 1'b0;
    end else begin
      oper_prev <= operational;
      peer_prev <= peer_port_operational;
      if (solo_node |
          (oper_prev & ~operational) | (peer_prev & ~peer_port_operational) |
          (cfg_wr & pwdata[`SPBU_CFG_REFL_BIT])) begin
        reflect_tokens_indicator <= 1'b1;
      end else if (cfg_wr & ~pwdata[`SPBU_CFG_REFL_BIT] &
                   operational & peer_port_operational) begin
        reflect_tokens_indicator <= 1'b0;
      end
    end
  end

endmodule

/* spbu_bringup_props.sv */
// spbu_bringup_props.sv: port-level checks of the link bring-up block
// assumes only the top-level ports are visible; bound after the module
`timescale 1ns/1ns
module spbu_bringup_props (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  // line and node status
  input wire        line_fault,
  input wire        char_sync,
  input wire        flag_decoded,
  input wire        rx_ready_pair,
  input wire        rx_space_avail,
  input wire        peer_port_operational,
  input wire        tx_char_done,
  // port outputs
  input wire [1:0]  tx_char_sel,
  input wire [1:0]  port_state,
  input wire        privileged_mode,
  input wire        operational,
  input wire        privileged_traffic_ok,
  input wire        reflect_tokens_indicator
);
  reg  [7:0] n_idle;
  reg  [7:0] n_train;
  reg        peer_seen;
  wire       wr = psel && penable && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_idle <= 8'h00;
      n_train <= 8'h00;
      peer_seen <= 1'b0;
    end else begin
      n_idle <= !operational ? 8'h00 :
                (tx_char_done && tx_char_sel == 2'h2 && n_idle != 8'hff) ? n_idle + 8'h01 : n_idle;
      n_train <= (tx_char_sel != 2'h1) ? 8'h00 :
                 (tx_char_done && n_train != 8'hff) ? n_train + 8'h01 : n_train;
      peer_seen <= operational && (peer_seen || rx_ready_pair);
    end
  end
  sequence s_ready_entry;
    port_state != 2'h2 ##1 port_state == 2'h2;
  endsequence
  sequence s_pair_start;
    tx_char_sel != 2'h3 ##1 tx_char_sel == 2'h3;
  endsequence
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_restart_disables: assert property (wr && pwdata[3:0] != 4'h0 &&
    (paddr == 8'h04 || paddr == 8'h08) |=> port_state == 2'h0 && privileged_mode && !operational)
    else $error("port not disabled after restart");
  a_fault_stalls: assert property (line_fault [*3] ##0 tx_char_sel == 2'h0
    |=> tx_char_sel == 2'h0) else $error("left fault wait while fault present");
  a_oper_on_ready: assert property ($rose(operational) |-> port_state == 2'h2)
    else $error("operational set outside ready");
  a_ready_cause: assert property (s_ready_entry |->
    $past(port_state) == 2'h1 && $past(char_sync && flag_decoded))
    else $error("ready without sync and idle char");
  a_idle_before_pair: assert property (s_pair_start |-> n_idle >= 8'h0a)
    else $error("ready pair before ten idle chars");
  a_pair_needs_space: assert property (s_pair_start |-> $past(rx_space_avail))
    else $error("ready pair without receive space");
  a_ok_after_peer: assert property ($rose(privileged_traffic_ok) |-> peer_seen)
    else $error("traffic allowed before peer pair");
  a_train_before_enab: assert property ($rose(port_state == 2'h1) |->
    n_train >= 8'hc8) else $error("enabled before 200 training chars");
  a_enab_sends_idle: assert property (port_state == 2'h1 |-> tx_char_sel == 2'h2)
    else $error("enabled state not sending idle chars");
  a_reflect_on_drop: assert property (
    $fell(peer_port_operational) || $fell(operational) |=> reflect_tokens_indicator)
    else $error("reflect not set on port drop");
  a_reflect_clear: assert property ($fell(reflect_tokens_indicator) |-> $past(wr &&
    paddr == 8'h08 && !pwdata[4] && operational && peer_port_operational))
    else $error("reflect cleared without cause");
endmodule
bind spbu_link_bringup spbu_bringup_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .line_fault(line_fault),
  .char_sync(char_sync), .flag_decoded(flag_decoded), .rx_ready_pair(rx_ready_pair),
  .rx_space_avail(rx_space_avail), .peer_port_operational(peer_port_operational),
  .tx_char_done(tx_char_done), .tx_char_sel(tx_char_sel), .port_state(port_state),
  .privileged_mode(privileged_mode), .operational(operational),
  .privileged_traffic_ok(privileged_traffic_ok),
  .reflect_tokens_indicator(reflect_tokens_indicator));

/* spbu_peer_port.sv */
// spbu_peer_port.sv: remote port and local transmitter stand-in
// assumes one char per cycle, every other cycle when slow
`timescale 1ns/1ns
module spbu_peer_port (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // bench controls
  input  wire       link_up,
  input  wire       want_400,
  input  wire       flag_en,
  input  wire       slow,
  // local port transmit side
  input  wire [1:0] tx_char_sel,
  input  wire       rate_400,
  // link status back to the port
  output reg        char_sync,
  output reg        flag_decoded,
  output reg        tx_char_done,
  output reg        rx_ready_pair
);
  reg  [3:0] lock_cnt;
  reg  [3:0] pair_dly;
  wire       match = link_up && (rate_400 == want_400);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 4'h0;
      pair_dly <= 4'h0;
      char_sync <= 1'b0;
      flag_decoded <= 1'b0;
      tx_char_done <= 1'b0;
      rx_ready_pair <= 1'b0;
    end else begin
      tx_char_done <= (tx_char_sel != 2'h0) && !(slow && tx_char_done);
      // sync only after a run of cycles at the peer's own rate
      lock_cnt <= !match ? 4'h0 : (lock_cnt == 4'hf) ? lock_cnt : lock_cnt + 4'h1;
      char_sync <= match && (lock_cnt == 4'hf);
      flag_decoded <= match && flag_en && char_sync;
      pair_dly <= (tx_char_done && tx_char_sel == 2'h3) ? 4'h6 :
                  (pair_dly != 4'h0) ? pair_dly - 4'h1 : 4'h0;
      rx_ready_pair <= (pair_dly == 4'h1);
    end
  end
endmodule

/* tb_serial_port_link_bringup.sv */
// tb_serial_port_link_bringup.sv: self-checking bench for the bring-up block
// assumes the peer model closes the link; dual-speed steps shortened
`timescale 1ns/1ns
`include "spbu_regs.vh"
module tb_serial_port_link_bringup;
  localparam [16:0] S0 = 17'h12c, S1 = 17'h104, S2 = 17'h0f0, S3 = 17'h118;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, last_rd, r;
  reg         line_fault = 1'b1, rx_space_avail = 1'b0, peer_port_operational = 1'b1;
  reg         want_400 = 1'b1, flag_en = 1'b1, slow = 1'b0, rd_chk = 1'b0, step_mon = 1'b0;
  reg         armed = 1'b0, last_rate = 1'b1;
  reg  [65:0] q[$], ent;
  reg  [32:0] qs[$];
  integer     fails = 0, n_compared = 0, cyc = 0, i, k;
  wire        pready, pslverr, char_sync, flag_decoded, rx_ready_pair, tx_char_done, rate_400;
  wire        privileged_mode, operational, privileged_traffic_ok, reflect_tokens_indicator;
  wire [31:0] prdata;
  wire [1:0]  tx_char_sel, port_state;
  always #2 pclk = ~pclk;
  spbu_link_bringup #(.STEP0_CYC(S0), .STEP1_CYC(S1), .STEP2_CYC(S2), .STEP3_CYC(S3)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .line_fault(line_fault), .char_sync(char_sync), .flag_decoded(flag_decoded),
    .rx_ready_pair(rx_ready_pair), .rx_space_avail(rx_space_avail),
    .peer_port_operational(peer_port_operational), .tx_char_done(tx_char_done),
    .tx_char_sel(tx_char_sel), .rate_400(rate_400), .port_state(port_state),
    .privileged_mode(privileged_mode), .operational(operational),
    .privileged_traffic_ok(privileged_traffic_ok),
    .reflect_tokens_indicator(reflect_tokens_indicator));
  spbu_peer_port u_peer (.pclk(pclk), .presetn(presetn), .link_up(1'b1), .want_400(want_400),
    .flag_en(flag_en), .slow(slow), .tx_char_sel(tx_char_sel), .rate_400(rate_400),
    .char_sync(char_sync), .flag_decoded(flag_decoded), .tx_char_done(tx_char_done),
    .rx_ready_pair(rx_ready_pair));
  task report_and_stop;
    begin
      if (fails == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task give_up;
    begin
      fails = fails + 1;
      report_and_stop;
    end
  endtask
  task chk(input [32:0] got, input [32:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 64) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n == 64)
        give_up;
      last_rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [7:0] a, input [32:0] m, input [32:0] v);
    begin
      q.push_back({m, v});
      rd_chk <= 1'b1;
      apb(a, 1'b0, 32'h0);
    end
  endtask
  task wait_fsm(input [7:0] f);
    begin
      rd_chk <= 1'b0;
      i = 0;
      last_rd = 32'h0;
      while (last_rd[7:0] !== f && i < 800) begin
        apb(`SPBU_STATUS_OFS, 1'b0, 32'h0);
        i = i + 1;
      end
      if (last_rd[7:0] !== f)
        give_up;
    end
  endtask
  task refl(input [7:0] a, input [31:0] d, input e);
    begin
      apb(a, 1'b1, d);
      rd(`SPBU_STATUS_OFS, 33'h400, {22'h0, e, 10'h0});
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rd_chk) begin
      if (q.size() == 0)
        fails = fails + 1;
      else begin
        ent = q.pop_front();
        chk({pslverr, prdata} & ent[65:33], ent[32:0]);
      end
    end
  end
  // step lengths: cycles between rate changes
  always @(negedge pclk) begin
    cyc = cyc + 1;
    if (step_mon && rate_400 !== last_rate) begin
      if (armed && qs.size() > 0)
        chk({rate_400, 16'h0, cyc[15:0]}, qs.pop_front());
      armed = 1'b1;
      cyc = 0;
    end
    last_rate = rate_400;
  end
  initial begin
    r = $urandom(32'h368419c9);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SPBU_STATUS_OFS, 33'he5ff, 33'h2401);
    rd(`SPBU_CTRL_OFS, 33'h1_ffff_ffff, 33'h0);
    rd(`SPBU_CFGMSG_OFS, 33'h1_ffff_ffff, 33'h0);
    rd(`SPBU_EVENT_OFS, 33'h1_ffff_ffff, 33'h0);
    rd(8'h10, 33'h1_ffff_ffff, 33'h1_0000_0000);
    repeat (40) @(posedge pclk);
    rd(`SPBU_STATUS_OFS, 33'hff, 33'h01);
    line_fault <= 1'b0;
    wait_fsm(8'h10);
    repeat (20) @(posedge pclk);
    rd(`SPBU_STATUS_OFS, 33'hf_e1ff, 33'h5_a110);
    rx_space_avail <= 1'b1;
    wait_fsm(8'h80);
    rd(`SPBU_STATUS_OFS, 33'hf_e1ff, 33'h0_a180);
    chk({32'h0, privileged_traffic_ok}, 33'h1);
    refl(`SPBU_CFGMSG_OFS, 32'h20, 1'b0);
    refl(`SPBU_CFGMSG_OFS, 32'h30, 1'b1);
    refl(`SPBU_CFGMSG_OFS, 32'h20, 1'b0);
    peer_port_operational <= 1'b0;
    refl(`SPBU_CTRL_OFS, 32'h0, 1'b1);
    peer_port_operational <= 1'b1;
    refl(`SPBU_CFGMSG_OFS, 32'h20, 1'b0);
    refl(`SPBU_CTRL_OFS, 32'h2, 1'b1);
    refl(`SPBU_CFGMSG_OFS, 32'h20, 1'b1);
    apb(`SPBU_CTRL_OFS, 1'b1, 32'h0);
    for (k = 0; k < 5; k = k + 1) begin
      r = $urandom;
      slow <= r[4];
      if (k < 4)
        apb(`SPBU_EVENT_OFS, 1'b1, 32'h1 << k);
      else
        apb(`SPBU_CFGMSG_OFS, 1'b1, {28'h0, r[3:0] | 4'h1});
      rd(`SPBU_STATUS_OFS, 33'he100, 33'h2000);
      chk({32'h0, privileged_traffic_ok}, 33'h0);
      wait_fsm(8'h80);
    end
    slow <= 1'b0;
    want_400 <= 1'b0;
    flag_en <= 1'b0;
    apb(`SPBU_CTRL_OFS, 1'b1, 32'h1);
    qs.push_back({1'b1, 16'h0, S1[15:0]});
    qs.push_back({1'b0, 16'h0, S2[15:0]});
    qs.push_back({1'b1, 16'h0, S3[15:0]});
    qs.push_back({1'b0, 16'h0, S0[15:0]});
    step_mon <= 1'b1;
    apb(`SPBU_EVENT_OFS, 1'b1, 32'h1);
    i = 0;
    while (qs.size() > 0 && i < 3000) begin
      @(posedge pclk);
      i = i + 1;
    end
    if (qs.size() > 0)
      give_up;
    step_mon <= 1'b0;
    flag_en <= 1'b1;
    wait_fsm(8'h80);
    rd(`SPBU_STATUS_OFS, 33'he380, 33'ha180);
    report_and_stop;
  end
endmodule
